// ### sts_pkg.sv
package sts_pkg;
   // *****************************************
   // command decode
   // *****************************************
   localparam logic [7:0] CMD_RELIAB = 8'hB0;
   localparam logic [7:0] FEAT_THRESH = 8'hD1;
   localparam logic [7:0] FEAT_STATUS = 8'hDA;
   localparam logic [7:0] SIG_LOW_OK = 8'h4F;
   localparam logic [7:0] SIG_HIGH_OK = 8'hC2;
   localparam logic [7:0] SIG_LOW_FAIL = 8'hF4;
   localparam logic [7:0] SIG_HIGH_FAIL = 8'h2C;
   localparam logic [2:0] DRVHEAD_ONES = 3'h7;
   localparam int DRVHEAD_TOP_POS = 5;
   // *****************************************
   // sector layout
   // *****************************************
   localparam int SECTOR_BYTES = 512;
   localparam logic [15:0] STRUCT_VERSION = 16'h0010;
   localparam int ENTRY_BASE = 2;
   localparam int ENTRY_BYTES = 12;
   localparam int ENTRY_COUNT = 30;
   localparam int ENTRY_END = ENTRY_BASE + ENTRY_BYTES * ENTRY_COUNT;
   localparam int CHECKSUM_POS = 511;
   localparam int ID_POS = 0;
   localparam int THR_POS = 1;
   // *****************************************
   // attribute table
   // *****************************************
   localparam int USED_ENTRIES = 11;
   localparam logic [7:0] ID_SPARE = 8'hC4;
   localparam logic [7:0] ID_SPARE_WORST = 8'hD5;
   localparam logic [7:0] ID_ERASE = 8'hE5;
   localparam logic [7:0] ID_ECC_TOTAL = 8'hCB;
   localparam logic [7:0] ID_ECC_CORR = 8'hCC;
   localparam logic [7:0] ID_CRC = 8'hC7;
   localparam logic [7:0] ID_READS = 8'hE8;
   localparam logic [7:0] ID_POWER_ON = 8'h0C;
   localparam logic [7:0] ID_WRITTEN = 8'hF1;
   localparam logic [7:0] ID_READ = 8'hF2;
   localparam logic [7:0] ID_ANCHOR = 8'hD6;
   localparam logic [7:0] ID_TRIM = 8'hD7;
   localparam logic [7:0] THR_SPARE_DEF = 8'h19;
   localparam logic [7:0] THR_ERASE_DEF = 8'h01;
   localparam logic [7:0] THR_NONE = 8'h00;
   localparam int BUF_DEPTH = 2;
endpackage

// ### sts_skid.sv
module sts_skid #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_out = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### sts_core.sv
module sts_core #(
   parameter logic [7:0] THR_SPARE = sts_pkg::THR_SPARE_DEF,
   parameter logic [7:0] THR_ERASE = sts_pkg::THR_ERASE_DEF
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // task-file command strobe and registers
   input wire logic cmd_strobe_in,
   input wire logic [7:0] command_in,
   input wire logic [7:0] features_in,
   input wire logic [7:0] cyl_low_in,
   input wire logic [7:0] cyl_high_in,
   input wire logic [7:0] drive_head_in,
   // current normalized attribute values
   input wire logic [7:0] spare_value_in,
   input wire logic [7:0] erase_value_in,
   // status signature back to the task file
   output logic sig_load_out,
   output logic [7:0] sig_cyl_low_out,
   output logic [7:0] sig_cyl_high_out,
   // sector byte stream
   output logic data_valid_out,
   input wire logic data_ready_in,
   output logic [7:0] data_out,
   output logic data_last_out,
   // activity and rejection
   output logic busy_out,
   output logic cmd_reject_out
);
   // ***********************************************
   // decode
   // ***********************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } sts_state_t;

   sts_state_t state;
   logic [9:0] byte_idx;
   logic [7:0] sum;
   logic [7:0] next_byte;
   logic sig_ok;
   logic dh_ok;
   logic is_thresh;
   logic is_status;
   logic exceeded;
   logic gen_valid;
   logic gen_ready;
   logic gen_last;
   logic [8:0] buf_out;

   // the host owns the drive/head ones; a violating request is refused
   assign dh_ok = (drive_head_in[7:sts_pkg::DRVHEAD_TOP_POS] == sts_pkg::DRVHEAD_ONES);
   assign sig_ok = (cyl_low_in == sts_pkg::SIG_LOW_OK) && (cyl_high_in == sts_pkg::SIG_HIGH_OK);
   assign is_thresh = cmd_strobe_in && (command_in == sts_pkg::CMD_RELIAB) && sig_ok && dh_ok
                      && (features_in == sts_pkg::FEAT_THRESH);
   assign is_status = cmd_strobe_in && (command_in == sts_pkg::CMD_RELIAB) && sig_ok && dh_ok
                      && (features_in == sts_pkg::FEAT_STATUS);

   // a zero threshold never trips, so only nonzero limits are compared
   assign exceeded = ((THR_SPARE != sts_pkg::THR_NONE) && (spare_value_in <= THR_SPARE))
                  || ((THR_ERASE != sts_pkg::THR_NONE) && (erase_value_in <= THR_ERASE));

   // ***********************************************
   // sector byte generator
   // ***********************************************
   function automatic logic [7:0] entry_id(input int slot);
      case (slot)
         0: entry_id = sts_pkg::ID_SPARE;
         1: entry_id = sts_pkg::ID_SPARE_WORST;
         2: entry_id = sts_pkg::ID_ERASE;
         3: entry_id = sts_pkg::ID_ECC_TOTAL;
         4: entry_id = sts_pkg::ID_ECC_CORR;
         5: entry_id = sts_pkg::ID_CRC;
         6: entry_id = sts_pkg::ID_READS;
         7: entry_id = sts_pkg::ID_POWER_ON;
         8: entry_id = sts_pkg::ID_WRITTEN;
         9: entry_id = sts_pkg::ID_READ;
         10: entry_id = sts_pkg::ID_ANCHOR;
         11: entry_id = sts_pkg::ID_TRIM;
         default: entry_id = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] entry_thr(input int slot);
      case (slot)
         0: entry_thr = THR_SPARE;
         2: entry_thr = THR_ERASE;
         default: entry_thr = sts_pkg::THR_NONE;
      endcase
   endfunction

   // slot arithmetic stays in int; byte_idx never passes 511 while sending
   always_comb begin
      int pos;
      int slot;
      int ofs;
      pos = int'(byte_idx);
      slot = 0;
      ofs = 0;
      next_byte = 8'h00;
      if (pos == 0) begin
         next_byte = sts_pkg::STRUCT_VERSION[7:0];
      end else if (pos == 1) begin
         next_byte = sts_pkg::STRUCT_VERSION[15:8];
      end else if (pos < sts_pkg::ENTRY_END) begin
         slot = (pos - sts_pkg::ENTRY_BASE) / sts_pkg::ENTRY_BYTES;
         ofs = (pos - sts_pkg::ENTRY_BASE) % sts_pkg::ENTRY_BYTES;
         if (ofs == sts_pkg::ID_POS) begin
            next_byte = entry_id(slot);
         end else if (ofs == sts_pkg::THR_POS) begin
            next_byte = entry_thr(slot);
         end
      end else if (pos == sts_pkg::CHECKSUM_POS) begin
         next_byte = 8'(8'h00 - sum);
      end
   end

   assign gen_valid = (state == ST_SEND);
   // the checksum byte is the last one handed to the buffer
   assign gen_last = (byte_idx == 10'(sts_pkg::CHECKSUM_POS));

   // ***********************************************
   // control
   // ***********************************************
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         byte_idx <= '0;
         sum <= 8'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (is_thresh) begin
                  state <= ST_SEND;
                  byte_idx <= '0;
                  sum <= 8'h00;
               end
            end
            ST_SEND: begin
               if (gen_ready) begin
                  sum <= sum + next_byte;
                  byte_idx <= byte_idx + 10'h001;
                  if (gen_last) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // signature stays until the next status check
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sig_load_out <= 1'b0;
         sig_cyl_low_out <= sts_pkg::SIG_LOW_OK;
         sig_cyl_high_out <= sts_pkg::SIG_HIGH_OK;
      end else begin
         sig_load_out <= is_status && (state == ST_IDLE);
         if (is_status && (state == ST_IDLE)) begin
            sig_cyl_low_out <= exceeded ? sts_pkg::SIG_LOW_FAIL : sts_pkg::SIG_LOW_OK;
            sig_cyl_high_out <= exceeded ? sts_pkg::SIG_HIGH_FAIL : sts_pkg::SIG_HIGH_OK;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_reject_out <= 1'b0;
      end else begin
         // anything else, or any command while the sector is still being generated (ST_SEND), not during the drain
         cmd_reject_out <= cmd_strobe_in && ((state != ST_IDLE) || !(is_thresh || is_status));
      end
   end

   // busy also covers the drain, so a stalled receiver keeps the block busy
   assign busy_out = (state != ST_IDLE) || data_valid_out;

   // ***********************************************
   // output buffer
   // ***********************************************
   // two entries so a receiver stall never drops a byte
   sts_skid #(
      .WIDTH(9),
      .DEPTH(sts_pkg::BUF_DEPTH)
   ) u_buf (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(gen_valid),
      .in_ready_out(gen_ready),
      .in_data_in({gen_last, next_byte}),
      .out_valid_out(data_valid_out),
      .out_ready_in(data_ready_in),
      .out_data_out(buf_out)
   );

   assign data_out = buf_out[7:0];
   assign data_last_out = buf_out[8];
endmodule

// ### sts_core_assertions.sv
module sts_core_assertions #(
   parameter logic [7:0] THR_SPARE = 8'h19,
   parameter logic [7:0] THR_ERASE = 8'h01
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // task file and attributes
   input wire logic cmd_strobe_in,
   input wire logic [7:0] command_in,
   input wire logic [7:0] features_in,
   input wire logic [7:0] cyl_low_in,
   input wire logic [7:0] cyl_high_in,
   input wire logic [7:0] drive_head_in,
   input wire logic [7:0] spare_value_in,
   input wire logic [7:0] erase_value_in,
   // results
   input wire logic sig_load_out,
   input wire logic [7:0] sig_cyl_low_out,
   input wire logic [7:0] sig_cyl_high_out,
   input wire logic data_valid_out,
   input wire logic data_ready_in,
   input wire logic [7:0] data_out,
   input wire logic data_last_out,
   input wire logic busy_out,
   input wire logic cmd_reject_out
);
   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // zero threshold disables its compare
   wire logic fail = (THR_SPARE != 8'h00 && spare_value_in <= THR_SPARE) ||
      (THR_ERASE != 8'h00 && erase_value_in <= THR_ERASE);
   sequence s_cmd(logic [7:0] f);
      cmd_strobe_in && command_in == 8'hB0 && features_in == f && cyl_low_in == 8'h4F &&
         cyl_high_in == 8'hC2 && drive_head_in[7:5] == 3'h7 && !busy_out;
   endsequence
   property p_pass;
      s_cmd(8'hDA) ##0 !fail |=> sig_load_out && sig_cyl_low_out == 8'h4F &&
         sig_cyl_high_out == 8'hC2;
   endproperty
   a_pass: assert property (p_pass) else $error("pass signature wrong");
   property p_fail;
      s_cmd(8'hDA) ##0 fail |=> sig_load_out && sig_cyl_low_out == 8'hF4 &&
         sig_cyl_high_out == 8'h2C;
   endproperty
   a_fail: assert property (p_fail) else $error("fail signature wrong");
   property p_rej;
      cmd_strobe_in && (command_in != 8'hB0 || drive_head_in[7:5] != 3'h7) |=> cmd_reject_out;
   endproperty
   a_rej: assert property (p_rej) else $error("bad command not refused");
   property p_first;
      s_cmd(8'hD1) |=> busy_out ##1 data_valid_out && data_out == 8'h10;
   endproperty
   a_first: assert property (p_first) else $error("sector start wrong");
   property p_hold;
      data_valid_out && !data_ready_in |=> data_valid_out && $stable(data_out) &&
         $stable(data_last_out);
   endproperty
   a_hold: assert property (p_hold) else $error("stalled byte changed");
   property p_end;
      data_valid_out && data_ready_in && data_last_out |=> !data_valid_out && !busy_out;
   endproperty
   a_end: assert property (p_end) else $error("data after last byte");
   property p_sig;
      $changed(sig_cyl_low_out) || $changed(sig_cyl_high_out) |-> sig_load_out;
   endproperty
   a_sig: assert property (p_sig) else $error("signature moved without load");
   property p_load;
      sig_load_out |-> $past(cmd_strobe_in) && $past(features_in) == 8'hDA;
   endproperty
   a_load: assert property (p_load) else $error("load without status check");
endmodule
bind sts_core sts_core_assertions #(.THR_SPARE(THR_SPARE), .THR_ERASE(THR_ERASE)) chk_u (
   .ref_clk_in, .rst_n_in, .cmd_strobe_in, .command_in, .features_in, .cyl_low_in,
   .cyl_high_in, .drive_head_in, .spare_value_in, .erase_value_in, .sig_load_out,
   .sig_cyl_low_out, .sig_cyl_high_out, .data_valid_out, .data_ready_in, .data_out,
   .data_last_out, .busy_out, .cmd_reject_out);

// ### sts_host_model.sv
module sts_host_model (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // control
   input wire logic slow_in,
   input wire logic clr_in,
   // byte stream
   input wire logic data_valid_in,
   input wire logic [7:0] data_in,
   input wire logic data_last_in,
   output logic data_ready_out,
   output logic [9:0] count_out,
   output logic [9:0] last_pos_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // sink with optional stalls
   // ****************************************
   logic [7:0] mem [512];
   logic [1:0] phase;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase <= 2'h0;
         data_ready_out <= 1'b0;
         count_out <= 10'h000;
         last_pos_out <= 10'h3FF;
      end else begin
         phase <= phase + 2'h1;
         // slow mode takes one byte in four so the buffer fills
         data_ready_out <= !slow_in || phase == 2'h0;
         if (clr_in) begin
            count_out <= 10'h000;
         end else if (data_valid_in && data_ready_out) begin
            mem[count_out[8:0]] <= data_in;
            count_out <= count_out + 10'h001;
            if (data_last_in) begin
               last_pos_out <= count_out;
            end
         end
      end
   end
endmodule

// ### smart_threshold_status_tb.sv
module smart_threshold_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // bench
   // ****************************************
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, cmd_strobe_in = 1'b0, slow = 1'b0, clr = 1'b0;
   logic [7:0] command_in = 8'h00, features_in = 8'h00, cyl_low_in = 8'h00, cyl_high_in = 8'h00;
   logic [7:0] drive_head_in = 8'h00, spare_value_in = 8'h64, erase_value_in = 8'h64;
   logic sig_load_out, data_valid_out, data_ready_in, data_last_out, busy_out, cmd_reject_out;
   logic [7:0] sig_cyl_low_out, sig_cyl_high_out, data_out;
   logic [9:0] count, last_pos;
   int mismatches = 0;
   int cmp_count = 0;
   always #2 ref_clk_in = ~ref_clk_in;
   sts_core dut_u (.ref_clk_in, .rst_n_in, .cmd_strobe_in, .command_in, .features_in,
      .cyl_low_in, .cyl_high_in, .drive_head_in, .spare_value_in, .erase_value_in,
      .sig_load_out, .sig_cyl_low_out, .sig_cyl_high_out, .data_valid_out, .data_ready_in,
      .data_out, .data_last_out, .busy_out, .cmd_reject_out);
   sts_host_model host_u (.ref_clk_in, .rst_n_in, .slow_in(slow), .clr_in(clr),
      .data_valid_in(data_valid_out), .data_in(data_out), .data_last_in(data_last_out),
      .data_ready_out(data_ready_in), .count_out(count), .last_pos_out(last_pos));
   task chk(string what, logic [9:0] seen, logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task issue(logic [7:0] cmd, logic [7:0] feat, logic [7:0] dh);
      @(posedge ref_clk_in);
      cmd_strobe_in <= 1'b1;
      command_in <= cmd;
      features_in <= feat;
      cyl_low_in <= 8'h4F;
      cyl_high_in <= 8'hC2;
      drive_head_in <= dh;
      @(posedge ref_clk_in);
      cmd_strobe_in <= 1'b0;
   endtask
   task wait_resp;
      int n;
      n = 0;
      #1;
      while (sig_load_out !== 1'b1 && cmd_reject_out !== 1'b1 && n < 4) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      if (n == 4) begin
         mismatches++;
         stop_test();
      end
   endtask
   task t_status(logic [7:0] sp, logic [7:0] er, logic bad);
      @(posedge ref_clk_in);
      spare_value_in <= sp;
      erase_value_in <= er;
      issue(8'hB0, 8'hDA, 8'hE0);
      wait_resp();
      chk("sig_load", sig_load_out, 1);
      chk("cyl_low", sig_cyl_low_out, bad ? 8'hF4 : 8'h4F);
      chk("cyl_high", sig_cyl_high_out, bad ? 8'h2C : 8'hC2);
      chk("status_reject", cmd_reject_out, 0);
      @(posedge ref_clk_in);
      #1;
      chk("sig_pulse", sig_load_out, 0);
   endtask
   task t_reject(logic [7:0] cmd, logic [7:0] feat, logic [7:0] dh);
      issue(cmd, feat, dh);
      wait_resp();
      chk("reject", cmd_reject_out, 1);
      chk("reject_load", sig_load_out, 0);
   endtask
   task t_sector(logic stall);
      logic [7:0] ids [12];
      logic [7:0] e [512];
      logic [7:0] s;
      int n;
      ids = '{8'hC4, 8'hD5, 8'hE5, 8'hCB, 8'hCC, 8'hC7, 8'hE8, 8'h0C, 8'hF1, 8'hF2, 8'hD6, 8'hD7};
      @(posedge ref_clk_in);
      slow <= stall;
      clr <= 1'b1;
      @(posedge ref_clk_in);
      clr <= 1'b0;
      issue(8'hB0, 8'hD1, 8'hF0);
      #1;
      chk("busy", busy_out, 1);
      // a second request while generating must bounce
      if (stall) t_reject(8'hB0, 8'hD1, 8'hE0);
      if (stall) t_reject(8'hB0, 8'hDA, 8'hE0);
      n = 0;
      while (count !== 10'd512 && n < 5000) begin
         @(posedge ref_clk_in);
         n++;
      end
      if (n == 5000) begin
         mismatches++;
         stop_test();
      end
      repeat (4) @(posedge ref_clk_in);
      chk("count", count, 10'd512);
      chk("last_pos", last_pos, 10'd511);
      chk("idle", busy_out, 0);
      e = '{default: 8'h00};
      e[0] = 8'h10;
      for (int k = 0; k < 12; k++) e[2 + 12 * k] = ids[k];
      e[3] = 8'h19;
      e[27] = 8'h01;
      s = 8'h00;
      for (int i = 0; i < 511; i++) s = s + e[i];
      e[511] = 8'h00 - s;
      for (int i = 0; i < 512; i++) chk("byte", host_u.mem[i], e[i]);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      t_status(8'h1A, 8'h02, 1'b0);
      t_status(8'h19, 8'hFF, 1'b1);
      t_status(8'hFF, 8'h01, 1'b1);
      t_status(8'h1A, 8'h00, 1'b1);
      t_reject(8'hEC, 8'hDA, 8'hE0);
      t_reject(8'hB0, 8'hDA, 8'h60);
      t_reject(8'hB0, 8'hD0, 8'hE0);
      t_sector(1'b0);
      t_sector(1'b1);
      t_status(8'h64, 8'h64, 1'b0);
      stop_test();
   end
endmodule
